/* File: core/mem_parity_refresh.sv */
// parity generation, parity checking and refresh sequencing for a memory controller
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// - one parity bit per written byte, bits 16/17
// - even parity, odd when forced
// - parity latches follow until data hold
// - nine-bit odd count marks byte bad
// - check only captured fast-bus read data
// - set sticky error when cycle completes
// - report enable clear blocks abort flag
// - enabled fast-bus read error raises abort
// - no abort without request and control valid
// - bipolar configuration gates off refresh
// - 30 us timebase sets refresh request
// - refresh starts cycle, row onto lines 07:03
// - busy access holds off refresh latch
// - block write pulse 60 ns after latch
// - latch pulse clears refresh request
// - five-bit row counter on timebase
// - refresh enables all chip gating
// - refresh ends after a fixed 112-cycle run
// - refresh steals stalled access undisturbed
// - 15 us timeout forces refresh in stall
// - sticky error written from bit 15
module mem_parity_refresh
  import mem_parity_refresh_pkg::*;
#(
  parameter int period_cycles = refresh_period_cycles,
  parameter int timeout_cycles = stall_timeout_cycles
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // memory side
  input wire logic mos_arrays,
  input wire logic [15:0] write_data,
  input wire logic [1:0] write_bytes,
  input wire logic data_hold,
  input wire logic [17:0] read_data,
  input wire logic fast_read_capture,
  input wire logic processor_request,
  input wire logic control_valid,
  input wire logic access_active,
  input wire logic access_stalled,
  input wire logic cycle_done,
  output mem_word_s mem_out,
  output logic parity_abort_flag,
  output logic refresh_cycle_request,
  output logic refresh_active,
  output logic refresh_address_select,
  output logic [7:0] memory_row_address_lines,
  output logic chip_enable_strobe,
  output logic write_inhibit,
  output logic refresh_done
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic report_enable;
    logic force_odd_parity;
    logic sticky_parity_error;
    logic [1:0] parity_hold;
    logic [17:0] captured;
    mem_word_s mem;
    logic abort;
    logic [31:0] tb_count;
    logic req;
    refresh_state_e rstate;
    logic [row_bits-1:0] row;
    logic [7:0] run_count;
    logic [31:0] wait_count;
    logic addr_sel;
    logic active;
    logic inhibit;
    logic done;
    logic chip_en;
    logic [7:0] row_lines;
  } state_s;

  state_s cur;
  state_s next_cur;

  // even parity bit for one byte, inverted when forced odd
  function automatic logic gen_parity(input logic [7:0] b, input logic odd);
    gen_parity = (^b) ^ odd;
  endfunction

  // a nine-bit group with an odd count of ones is bad
  function automatic logic group_bad(input logic [7:0] b, input logic p);
    group_bad = ^{p, b};
  endfunction

  logic bad_parity_any;
  logic parity_strobe;
  logic parity_error_set;
  logic tb_edge;
  logic timed_out;
  logic [1:0] gen_bits;

  always_comb begin
    gen_bits[0] = gen_parity(write_data[7:0], cur.force_odd_parity);
    gen_bits[1] = gen_parity(write_data[15:8], cur.force_odd_parity);
    bad_parity_any = group_bad(cur.captured[7:0], cur.captured[low_parity_bit])
                   | group_bad(cur.captured[15:8], cur.captured[high_parity_bit]);
    parity_strobe = processor_request & control_valid;
    parity_error_set = bad_parity_any & cycle_done;
    tb_edge = (cur.tb_count == 32'(period_cycles - 1));
    timed_out = (cur.wait_count >= 32'(timeout_cycles)) & access_stalled;
  end

  // next-state logic for registers, parity path and refresh sequencer
  always_comb begin
    logic do_write;
    do_write = 1'b0;
    next_cur = cur;
    // axi write channel
    if (s_awvalid && cur.awready) begin
      next_cur.aw_got = 1'b1;
      next_cur.aw_addr = s_awaddr;
      next_cur.awready = 1'b0;
    end
    if (s_wvalid && cur.wready) begin
      next_cur.w_got = 1'b1;
      next_cur.w_data = s_wdata;
      next_cur.w_strb = s_wstrb;
      next_cur.wready = 1'b0;
    end
    if (cur.aw_got && cur.w_got && !cur.bvalid) begin
      do_write = 1'b1;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = (cur.aw_addr == parity_ctrl_addr || cur.aw_addr == refresh_stat_addr) ?
                       resp_okay : resp_slverr;
      next_cur.aw_got = 1'b0;
      next_cur.w_got = 1'b0;
    end
    if (cur.bvalid && s_bready) begin
      next_cur.bvalid = 1'b0;
      next_cur.awready = 1'b1;
      next_cur.wready = 1'b1;
    end
    // register write effects
    if (do_write && cur.aw_addr == parity_ctrl_addr) begin
      if (cur.w_strb[0]) begin
        next_cur.report_enable = cur.w_data[report_enable_bit];
        next_cur.force_odd_parity = cur.w_data[force_odd_bit];
      end
      if (cur.w_strb[1]) begin
        next_cur.sticky_parity_error = cur.w_data[sticky_error_bit];
      end
    end
    // error detection wins over software clear
    if (parity_error_set) begin
      next_cur.sticky_parity_error = 1'b1;
    end
    // axi read channel
    if (s_arvalid && cur.arready) begin
      next_cur.arready = 1'b0;
      next_cur.rvalid = 1'b1;
      next_cur.rresp = resp_okay;
      next_cur.rdata = 32'h0;
      if (s_araddr == parity_ctrl_addr) begin
        next_cur.rdata[report_enable_bit] = cur.report_enable;
        next_cur.rdata[force_odd_bit] = cur.force_odd_parity;
        next_cur.rdata[sticky_error_bit] = cur.sticky_parity_error;
      end else if (s_araddr == refresh_stat_addr) begin
        next_cur.rdata[row_bits-1:0] = cur.row;
        next_cur.rdata[8] = cur.active;
        next_cur.rdata[9] = cur.req;
      end else begin
        next_cur.rresp = resp_slverr;
      end
    end
    if (cur.rvalid && s_rready) begin
      next_cur.rvalid = 1'b0;
      next_cur.arready = 1'b1;
    end
    // parity latches transparent while hold is low
    if (!data_hold) begin
      next_cur.parity_hold = gen_bits;
    end
    next_cur.mem.data = {cur.parity_hold, write_data};
    next_cur.mem.byte_en = write_bytes;
    next_cur.mem.write = (|write_bytes) & ~cur.inhibit;
    // data-out capture for fast-bus reads only
    if (fast_read_capture) begin
      next_cur.captured = read_data;
    end
    // abort flag gated by enable and strobe
    next_cur.abort = cur.report_enable & parity_strobe & bad_parity_any;
    // free-running timebase and row counter
    next_cur.tb_count = tb_edge ? 32'h0 : cur.tb_count + 32'h1;
    if (tb_edge) begin
      next_cur.row = cur.row + 5'h01;
      if (mos_arrays) begin
        next_cur.req = 1'b1;
      end
    end
    next_cur.addr_sel = 1'b0;
    next_cur.done = 1'b0;
    unique case (cur.rstate)
      ref_idle: begin
        next_cur.wait_count = 32'h0;
        if (cur.req && mos_arrays) begin
          if (!access_active) begin
            next_cur.rstate = ref_run;
            next_cur.addr_sel = 1'b1;
            next_cur.active = 1'b1;
            next_cur.run_count = 8'h0;
            next_cur.req = 1'b0;
          end else begin
            next_cur.rstate = ref_wait;
          end
        end
      end
      ref_wait: begin
        next_cur.wait_count = cur.wait_count + 32'h1;
        if (!access_active || timed_out) begin
          next_cur.rstate = ref_run;
          next_cur.addr_sel = 1'b1;
          next_cur.active = 1'b1;
          next_cur.run_count = 8'h0;
          next_cur.req = 1'b0;
        end
      end
      ref_run: begin
        next_cur.run_count = cur.run_count + 8'h01;
        if (cur.run_count == 8'(refresh_cycle_len - 1)) begin
          next_cur.rstate = ref_idle;
          next_cur.active = 1'b0;
          next_cur.done = 1'b1;
        end
      end
    endcase
    if (!mos_arrays) begin
      next_cur.req = 1'b0;
    end
    next_cur.inhibit = next_cur.active && (next_cur.run_count >= 8'(write_block_cycles));
    next_cur.chip_en = next_cur.active;
    next_cur.row_lines = next_cur.addr_sel ? {cur.row, 3'b000} : 8'h00;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
      cur.awready <= 1'b1;
      cur.wready <= 1'b1;
      cur.arready <= 1'b1;
      cur.rstate <= ref_idle;
    end else begin
      cur <= next_cur;
    end
  end

  assign s_awready = cur.awready;
  assign s_wready = cur.wready;
  assign s_bvalid = cur.bvalid;
  assign s_bresp = cur.bresp;
  assign s_arready = cur.arready;
  assign s_rvalid = cur.rvalid;
  assign s_rdata = cur.rdata;
  assign s_rresp = cur.rresp;
  assign mem_out = cur.mem;
  assign parity_abort_flag = cur.abort;
  assign refresh_cycle_request = cur.req;
  assign refresh_active = cur.active;
  assign refresh_address_select = cur.addr_sel;
  assign memory_row_address_lines = cur.row_lines;
  assign chip_enable_strobe = cur.chip_en;
  assign write_inhibit = cur.inhibit;
  assign refresh_done = cur.done;
endmodule

/* File: core/mem_parity_refresh_pkg.sv */
// shared constants and carriers for the parity and refresh control block
package mem_parity_refresh_pkg;
  // register map (byte addresses)
  localparam logic [3:0] parity_ctrl_addr = 4'h0;
  localparam logic [3:0] refresh_stat_addr = 4'h4;
  // parity control field positions
  localparam int report_enable_bit = 0;
  localparam int force_odd_bit = 2;
  localparam int sticky_error_bit = 15;
  // stored parity bit positions in the memory word
  localparam int low_parity_bit = 16;
  localparam int high_parity_bit = 17;
  // refresh figures
  localparam int clock_mhz = 250;
  localparam int refresh_period_ns = 30000;
  localparam int refresh_period_cycles = (refresh_period_ns * clock_mhz) / 1000;
  localparam int write_block_ns = 60;
  localparam int write_block_cycles = (write_block_ns * clock_mhz + 999) / 1000;
  localparam int stall_timeout_ns = 15000;
  localparam int stall_timeout_cycles = (stall_timeout_ns * clock_mhz) / 1000;
  localparam int row_bits = 5;
  localparam int row_lsb = 3;
  // a refresh run has to outlast the write block window, or the block never bites
  localparam int refresh_run_ns = 450;
  localparam int refresh_cycle_len = (refresh_run_ns * clock_mhz) / 1000;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  typedef enum logic [1:0] {
    ref_idle = 2'b00,
    ref_wait = 2'b01,
    ref_run = 2'b10
  } refresh_state_e;

  typedef struct packed {
    logic [17:0] data;
    logic write;
    logic [1:0] byte_en;
  } mem_word_s;
endpackage

/* File: verification/mem_parity_refresh_monitor.sv */
// concurrent checks on the parity and refresh block ports
`timescale 1ns/1ns
module mem_parity_refresh_monitor
  import mem_parity_refresh_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mos_arrays,
  input wire logic [15:0] write_data,
  input wire logic data_hold,
  input wire logic processor_request,
  input wire logic control_valid,
  input wire logic access_active,
  input wire logic access_stalled,
  input wire mem_word_s mem_out,
  input wire logic parity_abort_flag,
  input wire logic refresh_cycle_request,
  input wire logic refresh_active,
  input wire logic refresh_address_select,
  input wire logic [7:0] memory_row_address_lines,
  input wire logic chip_enable_strobe,
  input wire logic write_inhibit,
  input wire logic refresh_done
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // both stored parity bits share one sense
  pair_sense_a: assert property (!$past(data_hold) && !$past(data_hold, 2) &&
    $past(write_data) == $past(write_data, 2) |-> (^mem_out.data[7:0] ^ mem_out.data[16]) ==
    (^mem_out.data[15:8] ^ mem_out.data[17])) else $error("parity sense differs");
  parity_hold_a: assert property ($past(data_hold) && $past(data_hold, 2) |->
    $stable(mem_out.data[17:16])) else $error("parity moved while held");
  // abort only inside a fast-bus strobe
  abort_gate_a: assert property (parity_abort_flag |->
    $past(processor_request) && $past(control_valid)) else $error("abort without strobe");
  // refresh sequencing
  bipolar_off_a: assert property ($rose(refresh_cycle_request) |-> $past(mos_arrays))
    else $error("refresh asked with bipolar arrays");
  row_lines_a: assert property (!refresh_address_select |-> memory_row_address_lines == 8'h00)
    else $error("row lines driven outside select");
  holdoff_a: assert property ($rose(refresh_active) |->
    !$past(access_active) || $past(access_stalled)) else $error("refresh broke into access");
  gating_a: assert property (chip_enable_strobe == refresh_active)
    else $error("chip gating differs from refresh");
  done_bound_a: assert property ($rose(refresh_active) |-> ##[1:120] refresh_done)
    else $error("refresh never finished");
  select_clear_a: assert property (refresh_address_select |=> !refresh_cycle_request)
    else $error("request kept after select");
  // write pulse blocked from 60 ns into a refresh
  block_start_a: assert property ($rose(refresh_active) |-> ##15 write_inhibit)
    else $error("write block late");
  block_write_a: assert property (write_inhibit |=> !mem_out.write)
    else $error("write passed during block");
endmodule

bind mem_parity_refresh mem_parity_refresh_monitor mem_parity_refresh_monitor_i (.aclk, .aresetn, .mos_arrays,
  .write_data, .data_hold, .processor_request, .control_valid, .access_active, .access_stalled, .mem_out,
  .parity_abort_flag, .refresh_cycle_request, .refresh_active, .refresh_address_select, .memory_row_address_lines,
  .chip_enable_strobe, .write_inhibit, .refresh_done);

/* File: verification/far_side.sv */
// processor fast bus and one word of memory array
`timescale 1ns/1ns
module far_side
  import mem_parity_refresh_pkg::*;
(
  input wire logic aclk,
  input wire mem_word_s mem_out,
  input wire logic parity_abort_flag,
  output logic [15:0] write_data = '0,
  output logic [1:0] write_bytes = '0,
  output logic data_hold = '0,
  output logic [17:0] read_data = '0,
  output logic fast_read_capture = '0,
  output logic processor_request = '0,
  output logic control_valid = '0,
  output logic access_active = '0,
  output logic access_stalled = '0,
  output logic cycle_done = '0
);
  logic [17:0] store = '0;
  // write cycle, parity frozen before the word lands
  task automatic wr(input logic [15:0] d, input logic [1:0] b);
    @(posedge aclk);
    {access_active, processor_request, control_valid} <= 3'h7;
    write_data <= d;
    write_bytes <= b;
    @(posedge aclk);
    data_hold <= 1'h1;
    repeat (2) @(posedge aclk);
    store = (mem_out.data & {b, {8{b[1]}}, {8{b[0]}}}) | (store & ~{b, {8{b[1]}}, {8{b[0]}}});
    cycle_done <= 1'h1;
    @(posedge aclk);
    {cycle_done, data_hold, access_active, processor_request, control_valid} <= '0;
    write_data <= ~write_data; // released lines carry junk
  endtask
  // read cycle, fast or peripheral
  task automatic rd(input logic fast, output logic ab);
    @(posedge aclk);
    access_active <= 1'h1;
    {processor_request, control_valid, fast_read_capture} <= {3{fast}};
    read_data <= store;
    @(posedge aclk);
    fast_read_capture <= 1'h0;
    @(posedge aclk);
    cycle_done <= 1'h1;
    @(posedge aclk);
    ab = parity_abort_flag; // taken as control valid drops
    {cycle_done, access_active, processor_request, control_valid} <= '0;
    read_data <= ~store;
  endtask
  // long access, optionally stalled
  task automatic busy(input int n, input logic st);
    @(posedge aclk);
    access_active <= 1'h1;
    access_stalled <= st;
    repeat (n) @(posedge aclk);
    {access_active, access_stalled} <= '0;
  endtask
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the parity and refresh block
`timescale 1ns/1ns
module tb_top;
  import mem_parity_refresh_pkg::*;
  localparam int p = 150;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic mos_arrays = 1'h1;
  logic [3:0] s_awaddr = '0, s_araddr = '0, s_wstrb = 4'hf;
  logic [31:0] s_wdata = '0, s_rdata;
  logic s_awvalid = '0, s_wvalid = '0, s_bready = '0, s_arvalid = '0, s_rready = '0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, data_hold, fast_read_capture, processor_request;
  logic control_valid, access_active, access_stalled, cycle_done, parity_abort_flag, refresh_cycle_request;
  logic refresh_active, refresh_address_select, chip_enable_strobe, write_inhibit, refresh_done;
  logic [1:0] s_bresp, s_rresp, write_bytes;
  logic [15:0] write_data;
  logic [17:0] read_data;
  logic [7:0] memory_row_address_lines;
  logic [4:0] last;
  mem_word_s mem_out;
  int n_fail = 0, samples_checked = 0, n_sel = 0, trk = -1;
  always #2 aclk = ~aclk;
  mem_parity_refresh #(.period_cycles(p), .timeout_cycles(20)) mem_parity_refresh_i (.aclk, .aresetn,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .mos_arrays, .write_data,
    .write_bytes, .data_hold, .read_data, .fast_read_capture, .processor_request, .control_valid, .access_active,
    .access_stalled, .cycle_done, .mem_out, .parity_abort_flag, .refresh_cycle_request, .refresh_active,
    .refresh_address_select, .memory_row_address_lines, .chip_enable_strobe, .write_inhibit, .refresh_done);
  far_side far_side_i (.aclk, .mem_out, .parity_abort_flag, .write_data, .write_bytes, .data_hold, .read_data,
    .fast_read_capture, .processor_request, .control_valid, .access_active, .access_stalled, .cycle_done);
  // comparison, verdict and expectations
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [1:0] par(input logic [15:0] d, input logic odd);
    return {^d[15:8] ^ odd, ^d[7:0] ^ odd};
  endfunction
  function automatic logic bad(input logic [17:0] w);
    return (^w[15:8] ^ w[17]) | (^w[7:0] ^ w[16]);
  endfunction
  // register bus master
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      n++;
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
    end while (!s_bvalid && n < 50);
    s_bready <= 1'h0;
    chk(32'(s_bresp), 32'(er));
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      n++;
      if (s_arready) s_arvalid <= 1'h0;
    end while (!s_rvalid && n < 50);
    s_rready <= 1'h0;
    chk(s_rdata, ed);
    chk(32'(s_rresp), 32'(er));
  endtask
  // row order at each refresh select pulse
  always @(posedge aclk) begin
    if (refresh_address_select) begin
      n_sel++;
      if (trk == 1) chk(32'(memory_row_address_lines), 32'({last + 5'h1, 3'h0}));
      if (trk >= 0) trk = 1;
      last = memory_row_address_lines[7:3];
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    end_of_test();
  end
  initial begin
    logic ab;
    logic [15:0] d;
    int n0;
    void'($urandom(32'h9374c1e9));
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    axr(parity_ctrl_addr, 32'h0, resp_okay);
    axr(4'h8, 32'h0, resp_slverr);
    axw(4'h8, 32'hffff, resp_slverr);
    $display("registers done");
    // every mode and lane mix on random data
    for (int i = 0; i < 12; i++) begin
      d = 16'($urandom);
      axw(parity_ctrl_addr, 32'({i[0], 1'h0, i < 6}), resp_okay);
      far_side_i.wr(d, 2'(i % 3 + 1));
      chk(32'(far_side_i.store[17:16] & 2'(i % 3 + 1)), 32'(par(d, i[0]) & 2'(i % 3 + 1)));
      axw(parity_ctrl_addr, 32'({i[0], 1'h0, i < 6}), resp_okay);
      far_side_i.rd(1'h1, ab);
      chk(32'(ab), 32'(bad(far_side_i.store) & (i < 6)));
      axr(parity_ctrl_addr, 32'({bad(far_side_i.store), 12'h0, i[0], 1'h0, i < 6}), resp_okay);
    end
    // a peripheral read of a bad word stays silent
    axw(parity_ctrl_addr, 32'h1, resp_okay);
    far_side_i.wr(16'h1234, 2'h3);
    far_side_i.rd(1'h1, ab);
    axw(parity_ctrl_addr, 32'h5, resp_okay);
    far_side_i.wr(16'h1234, 2'h3);
    far_side_i.rd(1'h0, ab);
    chk(32'(ab), 32'h0);
    axr(parity_ctrl_addr, 32'h5, resp_okay);
    $display("parity done");
    // quiet run over a full row wrap, then bipolar arrays
    trk = 0;
    repeat (34 * p) @(posedge aclk);
    trk = -1;
    chk(32'(n_sel > 33), 32'h1);
    n0 = n_sel;
    mos_arrays <= 1'h0;
    repeat (3 * p) @(posedge aclk);
    mos_arrays <= 1'h1;
    chk(32'(n_sel - n0), 32'h0);
    // busy access holds refresh off, a stalled one is broken into
    n0 = n_sel;
    far_side_i.busy(2 * p, 1'h0);
    chk(32'(n_sel - n0), 32'h0);
    n0 = n_sel;
    far_side_i.busy(3 * p, 1'h1);
    chk(32'(n_sel - n0 > 1), 32'h1);
    $display("refresh done");
    end_of_test();
  end
endmodule
